// File: rxh_pkg.sv
package rxh_pkg;

	// port replication
	localparam int          NPORT       = 8;
	localparam int          PORT_LSB    = 9;
	localparam logic [11:0] PORT_STRIDE = 12'h200;

	// per-port register offsets
	localparam logic [8:0] OFF_HDLC_CTL = 9'h010;
	localparam logic [8:0] OFF_BIT_SUPP = 9'h011;
	localparam logic [8:0] OFF_MON_SEL  = 9'h012;
	localparam logic [8:0] OFF_SIG_CTL  = 9'h013;
	localparam logic [8:0] OFF_MON_DATA = 9'h017;
	localparam logic [8:0] OFF_STATUS   = 9'h018;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// receive hdlc control fields
	localparam int         CRC_BIT  = 7;
	localparam int         RST_BIT  = 6;
	localparam int         MAP_BIT  = 5;
	localparam int         CH_MSB   = 4;
	localparam logic [7:0] RST_MASK = 8'h40;

	// monitor select and signaling control fields
	localparam logic [7:0] MON_SEL_MASK    = 8'h1F;
	localparam logic [7:0] SIG_CTL_MASK    = 8'h17;
	localparam int         SIG_ONES_BIT    = 4;
	localparam int         FREEZE_FRC_BIT  = 2;
	localparam int         FREEZE_EN_BIT   = 1;

	// status register fields
	localparam int ST_FROZEN  = 0;
	localparam int ST_ALIGNED = 1;
	localparam int ST_OVERRUN = 2;

	// multiframe resync criterion and forced all-ones signaling value
	localparam logic [1:0] MAS_ERR_LIMIT = 2'h2;
	localparam logic [3:0] SIG_ALL_ONES  = 4'hF;

	// receive fifo word: port, epoch, kind, octet
	localparam int         FIFO_DEPTH = 4;
	localparam int         FIFO_WIDTH = 14;
	localparam int         QUEUE_LEN  = 3;
	localparam logic [1:0] KIND_DATA  = 2'h0;
	localparam logic [1:0] KIND_CRC   = 2'h1;
	localparam logic [1:0] KIND_END   = 2'h2;

endpackage

// File: rxh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rxh_fifo #(
	parameter int W = 14,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} rxh_fifo_st_t;

	rxh_fifo_st_t s;
	rxh_fifo_st_t next_s;
	logic         wr;
	logic         rd;

	assign in_ready  = (s.cnt != CW'(D));
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];

	always_comb begin
		next_s = s;
		wr = in_valid && in_ready;
		rd = out_valid && out_ready;
		if (wr) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
		end
		if (rd) begin
			next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
		end
		if (wr && !rd) begin
			next_s.cnt = s.cnt + CW'(1);
		end else if (rd && !wr) begin
			next_s.cnt = s.cnt - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// File: rxh_sig.sv
`timescale 1ns/1ps
`default_nettype none
module rxh_sig
	import rxh_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// controls
	input  wire logic       e1_mode,
	input  wire logic       force_signaling_ones,
	input  wire logic       signaling_force_freeze,
	input  wire logic       signaling_freeze_enable,
	input  wire logic       reinsert_en,
	// framer inputs
	input  wire logic [3:0] sig_in,
	input  wire logic       ones_chan,
	input  wire logic       freeze_event,
	input  wire logic       mas_seen,
	input  wire logic       mas_error,
	input  wire logic       ts16_prev_one,
	input  wire logic       mf_ts16_zero,
	// outputs
	output logic      [3:0] signaling_output,
	output logic      [3:0] serial_sig_output,
	output logic            frozen,
	output logic            mf_aligned,
	output logic            mf_resync
);

	typedef struct packed {
		logic [3:0] sig;
		logic [3:0] ser;
		logic [3:0] held;
		logic       frozen;
		logic [1:0] err_cnt;
		logic       aligned;
		logic       resync;
	} rxh_sig_st_t;

	rxh_sig_st_t s;
	rxh_sig_st_t next_s;
	logic        freeze;
	logic [3:0]  live;

	assign signaling_output  = s.sig;
	assign serial_sig_output = s.ser;
	assign frozen            = s.frozen;
	assign mf_aligned        = s.aligned;
	assign mf_resync         = s.resync;

	always_comb begin
		next_s = s;
		next_s.resync = 1'b0;
		freeze = signaling_force_freeze || (signaling_freeze_enable && freeze_event);
		live = (!e1_mode && force_signaling_ones && ones_chan) ? SIG_ALL_ONES : sig_in;
		if (!freeze) begin
			next_s.held = live;
		end
		next_s.frozen = freeze;
		next_s.sig = freeze ? s.held : live;
		next_s.ser = (freeze && reinsert_en) ? s.held : live;
		if (e1_mode) begin
			if (mas_error) begin
				if (s.err_cnt == MAS_ERR_LIMIT - 2'h1) begin
					next_s.resync = 1'b1;
					next_s.aligned = 1'b0;
					next_s.err_cnt = 2'h0;
				end else begin
					next_s.err_cnt = s.err_cnt + 2'h1;
				end
			end else if (mas_seen) begin
				next_s.err_cnt = 2'h0;
				// alternate mode needs a one in the preceding slot 16
				if (!s.aligned && (!force_signaling_ones || ts16_prev_one)) begin
					next_s.aligned = 1'b1;
				end
			end
			if (force_signaling_ones && s.aligned && mf_ts16_zero) begin
				next_s.resync = 1'b1;
				next_s.aligned = 1'b0;
			end
		end else begin
			next_s.err_cnt = 2'h0;
			next_s.aligned = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// File: rxh_top.sv
// What this block does
// - crc control pushes received crc after packet
// - hdlc reset clears controller, flushes fifo
// - hardware finishes reset within two frames, clears
// - init done also clears reset bit
// - mapping select: channel or fdl/sa bits
// - five-bit channel select, zero is channel one
// - new channel applies only after hdlc reset
// - per-bit suppress masks channel bits, msb bit7
// - monitor select picks channel for monitor data
// - t1 forced all-ones signaling on enabled channels
// - e1 resync after two bad alignment words
// - alternate cas: all-zero slot 16 resyncs
// - alternate cas alignment needs preceding one bit
// - force freeze holds signaling, overrides freeze enable
// - eight register copies at 200h stride
// - freeze enable lets freeze events hold signaling
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rxh_top
	import rxh_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// register port
	input  wire logic [11:0]      reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// framer timing, shared by all ports
	input  wire logic             e1_mode,
	input  wire logic             bit_strobe,
	input  wire logic [4:0]       chan_index,
	input  wire logic [2:0]       bit_index,
	input  wire logic             fdl_slot,
	input  wire logic             frame_start,
	input  wire logic             init_done_flag,
	// per-port receive data
	input  wire logic [7:0]       line_bit,
	input  wire logic [7:0]       pkt_end,
	// per-port signaling inputs
	input  wire logic [7:0][3:0]  sig_in,
	input  wire logic [7:0]       sig_ones_chan,
	input  wire logic [7:0]       reinsert_en,
	input  wire logic [7:0]       freeze_event,
	input  wire logic [7:0]       mas_seen,
	input  wire logic [7:0]       mas_error,
	input  wire logic [7:0]       ts16_prev_one,
	input  wire logic [7:0]       mf_ts16_zero,
	// per-port signaling outputs
	output logic      [7:0][3:0]  signaling_output,
	output logic      [7:0][3:0]  serial_sig_output,
	output logic      [7:0]       mf_aligned,
	output logic      [7:0]       mf_resync,
	// receive hdlc octet stream
	output logic                  hd_valid,
	input  wire logic             hd_ready,
	output logic      [2:0]       hd_port,
	output logic      [1:0]       hd_kind,
	output logic      [7:0]       hd_data
);

	typedef struct packed {
		logic [7:0][7:0]                  hctl;
		logic [7:0][7:0]                  supp;
		logic [7:0][7:0]                  mon_sel;
		logic [7:0][7:0]                  sig_ctl;
		logic [7:0][4:0]                  act_ch;
		logic [7:0]                       epoch;
		logic [7:0][7:0]                  shf;
		logic [7:0][2:0]                  bcnt;
		logic [7:0][7:0]                  h_old;
		logic [7:0][7:0]                  h_new;
		logic [7:0][1:0]                  hcnt;
		logic [7:0][QUEUE_LEN-1:0][9:0]   q;
		logic [7:0][1:0]                  qn;
		logic [7:0]                       ovr;
		logic [7:0][7:0]                  msh;
		logic [7:0][7:0]                  mdat;
		logic [7:0]                       rdata;
		logic                             o_valid;
		logic [2:0]                       o_port;
		logic [1:0]                       o_kind;
		logic [7:0]                       o_data;
	} rxh_st_t;

	rxh_st_t                   s;
	rxh_st_t                   next_s;
	logic [7:0]                frozen;
	logic [2:0]                sel;
	logic                      sel_ok;
	logic                      f_in_ready;
	logic [FIFO_WIDTH-1:0]     f_in_data;
	logic                      f_out_valid;
	logic                      f_out_pop;
	logic [FIFO_WIDTH-1:0]     f_out_data;
	logic                      drop;
	logic                      load;
	logic                      acc;
	logic [7:0]                oct;
	logic [QUEUE_LEN-1:0][9:0] ew;
	logic [1:0]                ne;
	logic [2:0]                wport;
	logic [8:0]                woff;
	logic [2:0]                rport;
	logic [8:0]                roff;

	assign reg_rdata = s.rdata;
	assign hd_valid  = s.o_valid;
	assign hd_port   = s.o_port;
	assign hd_kind   = s.o_kind;
	assign hd_data   = s.o_data;

	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_sig
			rxh_sig u_sig (
				.clk                     (clk),
				.reset_n                 (reset_n),
				.e1_mode                 (e1_mode),
				.force_signaling_ones    (s.sig_ctl[g][SIG_ONES_BIT]),
				.signaling_force_freeze  (s.sig_ctl[g][FREEZE_FRC_BIT]),
				.signaling_freeze_enable (s.sig_ctl[g][FREEZE_EN_BIT]),
				.reinsert_en             (reinsert_en[g]),
				.sig_in                  (sig_in[g]),
				.ones_chan               (sig_ones_chan[g]),
				.freeze_event            (freeze_event[g]),
				.mas_seen                (mas_seen[g]),
				.mas_error               (mas_error[g]),
				.ts16_prev_one           (ts16_prev_one[g]),
				.mf_ts16_zero            (mf_ts16_zero[g]),
				.signaling_output        (signaling_output[g]),
				.serial_sig_output       (serial_sig_output[g]),
				.frozen                  (frozen[g]),
				.mf_aligned              (mf_aligned[g]),
				.mf_resync               (mf_resync[g])
			);
		end
	endgenerate

	rxh_fifo #(
		.W (FIFO_WIDTH),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (sel_ok),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_pop),
		.out_data  (f_out_data)
	);

	always_comb begin
		next_s = s;
		acc = 1'b0;
		oct = 8'h00;
		ew = '0;
		ne = 2'h0;
		wport = reg_addr[11:PORT_LSB];
		woff = reg_addr[PORT_LSB-1:0];
		rport = reg_addr[11:PORT_LSB];
		roff = reg_addr[PORT_LSB-1:0];

		// lowest port with a queued word feeds the fifo
		sel_ok = 1'b0;
		sel = 3'h0;
		for (int p = NPORT - 1; p >= 0; p--) begin
			if (s.qn[p] != 2'h0) begin
				sel_ok = 1'b1;
				sel = 3'(p);
			end
		end
		f_in_data = {sel, s.epoch[sel], s.q[sel][0]};

		for (int p = 0; p < NPORT; p++) begin
			if (sel_ok && f_in_ready && sel == 3'(p)) begin
				next_s.q[p][0] = s.q[p][1];
				next_s.q[p][1] = s.q[p][2];
				next_s.qn[p] = s.qn[p] - 2'h1;
			end

			// bit selection into the hdlc controller
			if (s.hctl[p][MAP_BIT]) begin
				acc = bit_strobe && fdl_slot;
			end else begin
				acc = bit_strobe && chan_index == s.act_ch[p]
					&& !s.supp[p][bit_index];
			end
			ne = 2'h0;
			ew = '0;
			oct = {s.shf[p][6:0], line_bit[p]};
			if (pkt_end[p]) begin
				// last two octets are the received check code
				if (s.hcnt[p] == 2'h2 && s.hctl[p][CRC_BIT]) begin
					ew[0] = {KIND_CRC, s.h_old[p]};
					ew[1] = {KIND_CRC, s.h_new[p]};
					ew[2] = {KIND_END, 8'h00};
					ne = 2'h3;
				end else begin
					ew[0] = {KIND_END, 8'h00};
					ne = 2'h1;
				end
				next_s.hcnt[p] = 2'h0;
				next_s.bcnt[p] = 3'h0;
			end else if (acc) begin
				next_s.shf[p] = oct;
				next_s.bcnt[p] = s.bcnt[p] + 3'h1;
				if (s.bcnt[p] == 3'h7) begin
					next_s.h_new[p] = oct;
					next_s.h_old[p] = s.h_new[p];
					if (s.hcnt[p] == 2'h2) begin
						ew[0] = {KIND_DATA, s.h_old[p]};
						ne = 2'h1;
					end else begin
						next_s.hcnt[p] = s.hcnt[p] + 2'h1;
					end
				end
			end
			for (int k = 0; k < QUEUE_LEN; k++) begin
				if (2'(k) < ne) begin
					if (next_s.qn[p] == 2'(QUEUE_LEN)) begin
						next_s.ovr[p] = 1'b1;
					end else begin
						next_s.q[p][next_s.qn[p]] = ew[k];
						next_s.qn[p] = next_s.qn[p] + 2'h1;
					end
				end
			end

			// channel monitor capture, msb arrives first
			if (bit_strobe && chan_index == s.mon_sel[p][4:0]) begin
				next_s.msh[p] = {s.msh[p][6:0], line_bit[p]};
				if (bit_index == 3'h0) begin
					next_s.mdat[p] = {s.msh[p][6:0], line_bit[p]};
				end
			end

			// acknowledged hdlc reset, done at the next frame start or init done flag
			if (s.hctl[p][RST_BIT]) begin
				next_s.bcnt[p] = 3'h0;
				next_s.hcnt[p] = 2'h0;
				next_s.qn[p] = 2'h0;
				next_s.ovr[p] = 1'b0;
				if (frame_start || init_done_flag) begin
					next_s.hctl[p][RST_BIT] = 1'b0;
					next_s.act_ch[p] = s.hctl[p][CH_MSB:0];
					next_s.epoch[p] = !s.epoch[p];
				end
			end

			if (reg_wr && wport == 3'(p)) begin
				unique case (woff)
					OFF_HDLC_CTL: begin
						// host may set but never clear the reset bit
						next_s.hctl[p] = reg_wdata | (next_s.hctl[p] & RST_MASK);
					end
					OFF_BIT_SUPP: next_s.supp[p] = reg_wdata;
					OFF_MON_SEL:  next_s.mon_sel[p] = reg_wdata & MON_SEL_MASK;
					OFF_SIG_CTL:  next_s.sig_ctl[p] = reg_wdata & SIG_CTL_MASK;
					default: begin
					end
				endcase
			end
		end

		next_s.rdata = 8'h00;
		if (reg_rd) begin
			unique case (roff)
				OFF_HDLC_CTL: next_s.rdata = s.hctl[rport];
				OFF_BIT_SUPP: next_s.rdata = s.supp[rport];
				OFF_MON_SEL:  next_s.rdata = s.mon_sel[rport];
				OFF_SIG_CTL:  next_s.rdata = s.sig_ctl[rport];
				OFF_MON_DATA: next_s.rdata = s.mdat[rport];
				OFF_STATUS: begin
					next_s.rdata[ST_FROZEN] = frozen[rport];
					next_s.rdata[ST_ALIGNED] = mf_aligned[rport];
					next_s.rdata[ST_OVERRUN] = s.ovr[rport];
				end
				default: next_s.rdata = 8'h00;
			endcase
		end

		// words from before a port's last reset are discarded here
		drop = f_out_valid && (f_out_data[10] != s.epoch[f_out_data[13:11]]);
		load = !s.o_valid || hd_ready;
		f_out_pop = f_out_valid && (drop || load);
		if (load) begin
			next_s.o_valid = f_out_valid && !drop;
			next_s.o_port = f_out_data[13:11];
			next_s.o_kind = f_out_data[9:8];
			next_s.o_data = f_out_data[7:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// File: rxh_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxh_line_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// control
	input  wire logic       run,
	input  wire logic [7:0] end_mask,
	// framer timing
	output logic            bit_strobe,
	output logic      [4:0] chan_index,
	output logic      [2:0] bit_index,
	output logic            fdl_slot,
	output logic            frame_start,
	output logic      [7:0] pkt_end
);
	// 256 bit slots then one idle slot where packets close
	logic [8:0] cnt;
	logic [8:0] n;
	assign n = (cnt == 9'h100) ? 9'h000 : cnt + 9'h001;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 9'h100;
			bit_strobe <= 1'b0;
			chan_index <= 5'h00;
			bit_index <= 3'h7;
			fdl_slot <= 1'b0;
			frame_start <= 1'b0;
			pkt_end <= 8'h00;
		end else begin
			cnt <= n;
			bit_strobe <= run && n != 9'h100;
			chan_index <= n[7:3];
			bit_index <= ~n[2:0];
			fdl_slot <= n[5:0] == 6'h05;
			frame_start <= n == 9'h000;
			pkt_end <= (n == 9'h100) ? end_mask : 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: rxh_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rxh_top_chk
	import rxh_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// register port
	input  wire logic [11:0]     reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	input  wire logic [7:0]      reg_rdata,
	// signaling
	input  wire logic            e1_mode,
	input  wire logic [7:0][3:0] sig_in,
	input  wire logic [7:0]      sig_ones_chan,
	input  wire logic [7:0]      reinsert_en,
	input  wire logic [7:0]      freeze_event,
	input  wire logic [7:0]      mas_seen,
	input  wire logic [7:0]      mas_error,
	input  wire logic [7:0]      ts16_prev_one,
	input  wire logic [7:0]      mf_ts16_zero,
	input  wire logic [7:0][3:0] signaling_output,
	input  wire logic [7:0][3:0] serial_sig_output,
	input  wire logic [7:0]      mf_aligned,
	input  wire logic [7:0]      mf_resync
);
	// port 0 signaling control copy and errored-word parity
	logic [7:0] sc;
	logic       up;
	logic       pend;
	logic [3:0] ev;
	assign ev = (!e1_mode && sc[4] && sig_ones_chan[0]) ? 4'hF : sig_in[0];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sc <= 8'h00;
			up <= 1'b0;
			pend <= 1'b0;
		end else begin
			up <= 1'b1;
			if (reg_wr && reg_addr == {3'h0, OFF_SIG_CTL})
				sc <= reg_wdata & SIG_CTL_MASK;
			if (e1_mode && mas_error[0])
				pend <= !pend;
			else if (e1_mode && mas_seen[0])
				pend <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	chk_monsel_pad: assert property (
		reg_rd && reg_addr[8:0] == OFF_MON_SEL |=> (reg_rdata & ~MON_SEL_MASK) == 8'h00)
		else $error("monitor select pad bits set");
	chk_sigctl_pad: assert property (
		reg_rd && reg_addr[8:0] == OFF_SIG_CTL |=> (reg_rdata & ~SIG_CTL_MASK) == 8'h00)
		else $error("signaling control pad bits set");
	chk_freeze_off: assert property (
		up && !sc[2] && !(sc[1] && freeze_event[0]) |=> signaling_output[0] == $past(ev))
		else $error("signaling output not following");
	chk_force_ones: assert property (
		up && !e1_mode && sc[4] && sig_ones_chan[0] && sc[2:1] == 2'h0
		|=> signaling_output[0] == 4'hF) else $error("all ones not forced");
	chk_force_freeze: assert property (
		up && sc[2] |=> $stable(signaling_output[0])) else $error("forced freeze moved");
	chk_serial_thaw: assert property (
		up && !reinsert_en[0] |=> serial_sig_output[0] == $past(ev))
		else $error("serial signaling held without reinsertion");
	chk_resync_two: assert property (
		e1_mode && mas_error[0] && pend |=> mf_resync[0]) else $error("no resync after two errors");
	chk_ts16_resync: assert property (
		e1_mode && sc[4] && mf_aligned[0] && mf_ts16_zero[0] |=> mf_resync[0])
		else $error("no resync on zero slot 16");
	chk_align_one: assert property (
		e1_mode && sc[4] && !mf_aligned[0] && mas_seen[0] && !ts16_prev_one[0]
		|=> !mf_aligned[0]) else $error("aligned without slot 16 one");
	cov_resync: cover property (mf_resync[0]);
	cov_freeze: cover property (up && sc[2]);
	cov_ones: cover property (!e1_mode && sc[4] && sig_ones_chan[0]);
endmodule
bind rxh_top rxh_top_chk i_rxh_top_chk (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e1_mode(e1_mode),
	.sig_in(sig_in), .sig_ones_chan(sig_ones_chan), .reinsert_en(reinsert_en),
	.freeze_event(freeze_event), .mas_seen(mas_seen), .mas_error(mas_error),
	.ts16_prev_one(ts16_prev_one), .mf_ts16_zero(mf_ts16_zero),
	.signaling_output(signaling_output), .serial_sig_output(serial_sig_output),
	.mf_aligned(mf_aligned), .mf_resync(mf_resync)
);
`default_nettype wire

// File: rxh_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rxh_top_bench
	import rxh_pkg::*;
;
	logic            clk = 1'b0;
	logic            reset_n = 1'b0;
	logic [11:0]     reg_addr = 12'h000;
	logic [7:0]      reg_wdata = 8'h00;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic            e1_mode = 1'b0;
	logic            init_done_flag = 1'b0;
	logic            run = 1'b0;
	logic            hd_ready = 1'b0;
	logic [7:0]      line_bit = 8'h00;
	logic [7:0]      end_mask = 8'h00;
	logic [7:0]      ones = 8'h00;
	logic [7:0]      reins = 8'h00;
	logic [7:0]      frz = 8'h00;
	logic [7:0]      seen = 8'h00;
	logic [7:0]      merr = 8'h00;
	logic [7:0]      prev1 = 8'h00;
	logic [7:0]      zero16 = 8'h00;
	logic [7:0][3:0] sig_in = '0;
	logic [7:0][3:0] so, ss, exp_so, exp_ss;
	logic            bit_strobe, fdl_slot, frame_start, hd_valid;
	logic [4:0]      chan_index;
	logic [2:0]      bit_index, hd_port;
	logic [1:0]      hd_kind;
	logic [7:0]      pkt_end, hd_data, mf_al, mf_rs, rdat;
	logic [31:0]     seed = 32'h4F822264;
	logic [7:0]      shd [8][4];
	logic [4:0]      act [8];
	int              fails = 0, n_checks = 0, cyc = 0;
	int              sh[8], nb[8], mb[8], mon[8];
	int              hq[8][$], exq[8][$];
	bit              sig_on = 0;
	always #2 clk = ~clk;
	rxh_line_model i_rxh_line_model (.clk(clk), .reset_n(reset_n), .run(run),
		.end_mask(end_mask), .bit_strobe(bit_strobe), .chan_index(chan_index),
		.bit_index(bit_index), .fdl_slot(fdl_slot), .frame_start(frame_start), .pkt_end(pkt_end));
	rxh_top i_rxh_top (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .e1_mode(e1_mode),
		.bit_strobe(bit_strobe), .chan_index(chan_index), .bit_index(bit_index),
		.fdl_slot(fdl_slot), .frame_start(frame_start), .init_done_flag(init_done_flag),
		.line_bit(line_bit), .pkt_end(pkt_end), .sig_in(sig_in), .sig_ones_chan(ones),
		.reinsert_en(reins), .freeze_event(frz), .mas_seen(seen), .mas_error(merr),
		.ts16_prev_one(prev1), .mf_ts16_zero(zero16), .signaling_output(so),
		.serial_sig_output(ss), .mf_aligned(mf_al), .mf_resync(mf_rs), .hd_valid(hd_valid),
		.hd_ready(hd_ready), .hd_port(hd_port), .hd_kind(hd_kind), .hd_data(hd_data));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input int p, input logic [8:0] off, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= {p[2:0], off};
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input int p, input logic [8:0] off, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= {p[2:0], off};
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = rdat;
	endtask
	// stop traffic, drain, reset every hdlc receiver and wait for the self-clear
	task automatic settle(input logic fast);
		logic [7:0] d;
		int n;
		run <= 1'b0;
		for (int t = 0; t < 400; t++) begin
			n = 0;
			foreach (exq[p]) n += exq[p].size();
			if (n != 0) @(posedge clk);
		end
		check(n, 0);
		for (int p = 0; p < NPORT; p++) wr(p, OFF_HDLC_CTL, shd[p][0] | RST_MASK);
		init_done_flag <= fast;
		for (int p = 0; p < NPORT; p++) begin
			d = RST_MASK;
			for (int t = 0; t < 140 && d[RST_BIT]; t++) rd(p, OFF_HDLC_CTL, d);
			check(d, shd[p][0] & 8'hBF);
			act[p] = shd[p][0][4:0];
			hq[p] = {};
			nb[p] = 0;
		end
		init_done_flag <= 1'b0;
	endtask
	always @(posedge clk) begin
		logic [31:0] a, b, c, m;
		a = rnd();
		b = rnd();
		c = rnd();
		m = c[7:0] & c[15:8] & {8{e1_mode}};
		line_bit <= a[7:0];
		hd_ready <= a[8] | a[9];
		end_mask <= a[23:16] & a[31:24] & {8{run}};
		if (sig_on) begin
			sig_in <= b;
			ones <= a[15:8];
			frz <= a[23:16];
			reins <= a[31:24];
			prev1 <= c[31:24];
			seen <= m & ~c[23:16];
			merr <= m & c[23:16] & ~c[31:24];
			zero16 <= m & c[23:16] & c[31:24];
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			tally_and_finish();
		end
	end
	// reference model of signaling, octet stream and monitor
	always @(posedge clk) if (reset_n) begin
		int w;
		logic [3:0] v;
		logic fz;
		for (int p = 0; p < NPORT; p++) begin
			check({so[p], ss[p]}, {exp_so[p], exp_ss[p]});
			v = (!e1_mode && shd[p][3][4] && ones[p]) ? 4'hF : sig_in[p];
			fz = shd[p][3][2] || (shd[p][3][1] && frz[p]);
			if (!fz) exp_so[p] = v;
			exp_ss[p] = (fz && reins[p]) ? exp_so[p] : v;
			if (bit_strobe && chan_index == shd[p][2][4:0]) begin
				mb[p] = ((mb[p] << 1) | line_bit[p]) & 255;
				if (bit_index == 3'h0) mon[p] = mb[p];
			end
			if (bit_strobe && (shd[p][0][MAP_BIT] ? fdl_slot :
				chan_index == act[p] && !shd[p][1][bit_index])) begin
				sh[p] = ((sh[p] << 1) | line_bit[p]) & 255;
				nb[p]++;
				if (nb[p] == 8) begin
					nb[p] = 0;
					hq[p].push_back(sh[p]);
					if (hq[p].size() == 3) exq[p].push_back({KIND_DATA, 8'(hq[p].pop_front())});
				end
			end
			if (pkt_end[p]) begin
				if (shd[p][0][CRC_BIT] && hq[p].size() == 2) begin
					exq[p].push_back({KIND_CRC, 8'(hq[p][0])});
					exq[p].push_back({KIND_CRC, 8'(hq[p][1])});
				end
				exq[p].push_back({KIND_END, 8'h00});
				hq[p] = {};
				nb[p] = 0;
			end
		end
		if (hd_valid && hd_ready) begin
			w = exq[hd_port].size() ? exq[hd_port].pop_front() : 'hFFF;
			check({hd_kind, hd_kind == KIND_END ? 8'h00 : hd_data}, w[9:0]);
		end
		if (reg_wr && reg_addr[8:0] >= OFF_HDLC_CTL && reg_addr[8:0] <= OFF_SIG_CTL)
			shd[reg_addr[11:9]][reg_addr[1:0]] = reg_wdata;
	end
	initial begin
		logic [7:0] d;
		logic [7:0] msk [4];
		logic [31:0] r, q;
		msk = '{8'hBF, 8'hFF, MON_SEL_MASK, SIG_CTL_MASK};
		exp_so = '0;
		exp_ss = '0;
		foreach (shd[p, i]) shd[p][i] = REG_RESET;
		foreach (act[p]) act[p] = 5'h00;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		for (int p = 0; p < NPORT; p++)
			for (int i = 0; i < 4; i++) begin
				rd(p, OFF_HDLC_CTL + i, d);
				check(d, REG_RESET);
				r = rnd();
				wr(p, OFF_HDLC_CTL + i, r[7:0] & 8'hBF);
			end
		for (int p = 0; p < NPORT; p++) begin
			for (int i = 0; i < 4; i++) begin
				rd(p, OFF_HDLC_CTL + i, d);
				check(d, shd[p][i] & msk[i]);
			end
			wr(p, 9'h0FF, 8'hA5);
			rd(p, 9'h0FF, d);
			check(d, 8'h00);
		end
		for (int ph = 0; ph < 4; ph++) begin
			e1_mode <= ph[1];
			for (int p = 0; p < NPORT; p++) begin
				r = rnd();
				q = rnd();
				wr(p, OFF_HDLC_CTL, r[7:0] & 8'hBF);
				wr(p, OFF_BIT_SUPP, ph == 0 ? 8'h00 : r[15:8] & r[23:16]);
				wr(p, OFF_MON_SEL, r[31:24]);
				wr(p, OFF_SIG_CTL, q[7:0]);
			end
			settle(ph[0]);
			run <= 1'b1;
			sig_on = 1;
			repeat (8) begin
				repeat (600) @(posedge clk);
				r = rnd();
				wr(r[2:0], OFF_SIG_CTL, r[15:8]);
				wr(r[5:3], OFF_HDLC_CTL, (shd[r[5:3]][0] & 8'hBF) ^ 8'h01);
			end
			run <= 1'b0;
			repeat (4) @(posedge clk);
			for (int p = 0; p < NPORT; p++) begin
				rd(p, OFF_MON_DATA, d);
				check(d, mon[p]);
			end
		end
		settle(1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
